// ===== pkg/lad_pkg.sv
// Purpose: shared constants and types for the link activity indicator driver
// Assumes: 25 MHz core clock
// Notes: indicator outputs are active low (low = lamp on)
package lad_pkg;
  localparam logic [1:0] LAYOUT_FOUR = 2'h2;
  localparam logic [1:0] LAYOUT_FIVE = 2'h1;
  localparam logic [1:0] LAYOUT_SIX = 2'h3;
  localparam logic [1:0] LAYOUT_RESV = 2'h0;
  localparam logic [1:0] LAYOUT_RESET = 2'h3;
  localparam int LAYOUT_LSB = 6;
  localparam int LAYOUT_MSB = 7;
  localparam int CLK_HZ = 25000000;
  localparam int BLINK_PERIOD_MS = 80;
  // half period of the blink, a longest time so it rounds down
  localparam int BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
  localparam int BLINK_CNT_W = 20;

  typedef enum logic [1:0] {
    LAD_SPD_10 = 2'h0,
    LAD_SPD_100 = 2'h1,
    LAD_SPD_1000 = 2'h2
  } lad_speed_t;

  typedef struct packed {
    logic link_up;
    lad_speed_t speed;
    logic full_duplex;
    logic collision;
    logic tx_active;
    logic rx_active;
  } lad_status_t;

  typedef struct packed {
    logic transmit_activity_indicator;
    logic receive_activity_indicator;
    logic duplex_collision_indicator;
    logic gigabit_link_indicator;
    logic fast_link_indicator;
    logic tenmeg_link_indicator;
  } lad_lamps_t;
endpackage : lad_pkg

// ===== core/lad_driver.sv
// Purpose: drives six active-low indicator outputs for link, speed, duplex and activity
// Assumes: status inputs are asynchronous to sys_clk; layout select comes from a vendor register bit pair
// Notes: undriven outputs have enable low and read high through the pull-up
// Operation
// R1 - two-bit layout select picks four, five or six outputs; 00 reserved
// R2 - layout select resets to 11, six-output arrangement
// R3 - four-output layout: per-speed outputs low on link, toggle on activity
// R4 - four-output layout: receive and transmit activity outputs undriven, pulled high
// R5 - five-output layout: transmit output shows transmit or receive activity
// R6 - five-output layout: receive activity output undriven, pulled high
// R7 - six-output layout: receive and transmit activity on own outputs
// R8 - six-output layout: all driven, link outputs steady with no blinking
// R9 - activity blinks at about 12.5 Hz, an 80 ms period
// R10 - duplex output low for full, high for half, toggles on collisions
// R11 - status inputs synchronised, outputs follow within a few cycles
`timescale 1ns/1ps
module lad_driver (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic layout_wr,
  input wire logic [15:0] layout_wdata,
  input wire lad_pkg::lad_status_t status_in,
  output logic [1:0] indicator_layout_select,
  output lad_pkg::lad_lamps_t lamp_out,
  output lad_pkg::lad_lamps_t lamp_oe
);
  localparam int ST_W = $bits(lad_pkg::lad_status_t);

  logic [1:0] layout_r;
  logic [ST_W-1:0] sync1_r;
  logic [ST_W-1:0] sync2_r;
  logic [lad_pkg::BLINK_CNT_W-1:0] blink_cnt_r;
  logic blink_r;
  lad_pkg::lad_lamps_t lamp_r;
  lad_pkg::lad_lamps_t oe_r;

  // layout select register; reserved code is ignored so the lamps stay sensible
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      layout_r <= lad_pkg::LAYOUT_RESET; // [R2]
    end else if (layout_wr && layout_wdata[lad_pkg::LAYOUT_MSB:lad_pkg::LAYOUT_LSB] != lad_pkg::LAYOUT_RESV) begin
      layout_r <= layout_wdata[lad_pkg::LAYOUT_MSB:lad_pkg::LAYOUT_LSB]; // [R1]
    end
  end

  // two-stage synchroniser, status comes from other clock domains
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= status_in; // [R11]
      sync2_r <= sync1_r;
    end
  end

  lad_pkg::lad_status_t st;
  assign st = lad_pkg::lad_status_t'(sync2_r);

  // free-running blink phase, shared so all blinking lamps stay in step
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == lad_pkg::BLINK_CNT_W'(lad_pkg::BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_r <= '0;
      blink_r <= ~blink_r; // [R9]
    end else begin
      blink_cnt_r <= blink_cnt_r + 1'b1;
    end
  end

  // decode of the speed and activity conditions
  wire link10 = st.link_up && st.speed == lad_pkg::LAD_SPD_10;
  wire link100 = st.link_up && st.speed == lad_pkg::LAD_SPD_100;
  wire link1000 = st.link_up && st.speed == lad_pkg::LAD_SPD_1000;
  wire any_act = st.tx_active || st.rx_active;
  wire is_four = layout_r == lad_pkg::LAYOUT_FOUR;
  wire is_five = layout_r == lad_pkg::LAYOUT_FIVE;

  // active-low lamp level: on when link up, blink phase when active
  function automatic logic lamp_level(input logic on, input logic act, input logic ph);
    lamp_level = on ? (act ? ph : 1'b0) : 1'b1;
  endfunction : lamp_level

  // per-speed outputs blink only in the four-output layout
  wire act_link = is_four && any_act; // [R3] [R8]
  wire l10_nxt = lamp_level(link10, act_link, blink_r); // [R3] [R8]
  wire l100_nxt = lamp_level(link100, act_link, blink_r);
  wire l1000_nxt = lamp_level(link1000, act_link, blink_r);
  wire dup_nxt = st.collision ? blink_r : ~st.full_duplex; // [R10]
  // transmit lamp merges rx in five-output layout; tie-off high when undriven
  wire tx_nxt = is_four ? 1'b1 : is_five ? (any_act ? blink_r : 1'b1) : (st.tx_active ? blink_r : 1'b1); // [R5] [R7]
  wire rx_nxt = (is_four || is_five) ? 1'b1 : (st.rx_active ? blink_r : 1'b1); // [R4] [R6] [R7]
  wire tx_oe_nxt = !is_four; // [R4]
  wire rx_oe_nxt = !(is_four || is_five); // [R4] [R6]

  // registered outputs; enables low leave the pin to the pull-up
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lamp_r <= '1;
      oe_r <= '1;
    end else begin
      lamp_r <= '{tx_nxt, rx_nxt, dup_nxt, l1000_nxt, l100_nxt, l10_nxt};
      oe_r <= '{tx_oe_nxt, rx_oe_nxt, 1'b1, 1'b1, 1'b1, 1'b1}; // [R8]
    end
  end

  assign indicator_layout_select = layout_r;
  assign lamp_out = lamp_r;
  assign lamp_oe = oe_r;

  // lamps are registered, so each lamp check but the four-layout write check looks one edge back at the conditions that set them

  property p_reset_layout;
    @(posedge sys_clk) $fell(reset) |-> indicator_layout_select == lad_pkg::LAYOUT_RESET;
  endproperty
  a_reset_layout: assert property (p_reset_layout) else $error("layout not six after reset"); // [R2]

  property p_layout_write;
    @(posedge sys_clk) disable iff (reset)
      layout_wr && layout_wdata[lad_pkg::LAYOUT_MSB:lad_pkg::LAYOUT_LSB] != lad_pkg::LAYOUT_RESV |=>
        indicator_layout_select == $past(layout_wdata[lad_pkg::LAYOUT_MSB:lad_pkg::LAYOUT_LSB]);
  endproperty
  a_layout_write: assert property (p_layout_write) else $error("layout write lost"); // [R1]

  property p_resv_ignored;
    @(posedge sys_clk) disable iff (reset)
      layout_wr && layout_wdata[lad_pkg::LAYOUT_MSB:lad_pkg::LAYOUT_LSB] == lad_pkg::LAYOUT_RESV |=>
        $stable(indicator_layout_select);
  endproperty
  a_resv_ignored: assert property (p_resv_ignored) else $error("reserved layout accepted"); // [R1]

  property p_four_undriven;
    @(posedge sys_clk) disable iff (reset)
      $past(is_four) |-> !lamp_oe.transmit_activity_indicator && !lamp_oe.receive_activity_indicator;
  endproperty
  a_four_undriven: assert property (p_four_undriven) else $error("activity pins driven in four layout"); // [R4]

  property p_five_rx_off;
    @(posedge sys_clk) disable iff (reset)
      $past(is_five) |-> !lamp_oe.receive_activity_indicator && lamp_oe.transmit_activity_indicator;
  endproperty
  a_five_rx_off: assert property (p_five_rx_off) else $error("five layout enables wrong"); // [R6]

  property p_six_steady_link;
    @(posedge sys_clk) disable iff (reset)
      $past(layout_r == lad_pkg::LAYOUT_SIX && link10) |-> !lamp_out.tenmeg_link_indicator && lamp_oe == '1;
  endproperty
  a_six_steady_link: assert property (p_six_steady_link) else $error("six layout link lamp not steady"); // [R8]

  property p_link_off_high;
    @(posedge sys_clk) disable iff (reset)
      $past(!st.link_up) |-> lamp_out.gigabit_link_indicator && lamp_out.fast_link_indicator;
  endproperty
  a_link_off_high: assert property (p_link_off_high) else $error("link lamp on without link"); // [R3]

  property p_duplex;
    @(posedge sys_clk) disable iff (reset)
      $past(!st.collision) |-> lamp_out.duplex_collision_indicator == $past(!st.full_duplex);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex lamp wrong"); // [R10]

  property p_six_tx;
    @(posedge sys_clk) disable iff (reset)
      $past(layout_r == lad_pkg::LAYOUT_SIX && !st.tx_active) |-> lamp_out.transmit_activity_indicator;
  endproperty
  a_six_tx: assert property (p_six_tx) else $error("tx lamp on without tx"); // [R7]

  property p_five_merge;
    @(posedge sys_clk) disable iff (reset)
      $past(is_five && any_act) |-> lamp_out.transmit_activity_indicator == $past(blink_r);
  endproperty
  a_five_merge: assert property (p_five_merge) else $error("five layout merge wrong"); // [R5]

  property p_blink_period;
    @(posedge sys_clk) disable iff (reset)
      $changed(blink_r) |-> blink_cnt_r == 0;
  endproperty
  a_blink_period: assert property (p_blink_period) else $error("blink phase off count"); // [R9]

  property p_sync_latency;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |-> ##2 sync2_r == $past(status_in, 2);
  endproperty
  a_sync_latency: assert property (p_sync_latency) else $error("status sync latency"); // [R11]

  // a wrong terminal count would shift the 80 ms rate without any lamp looking odd
  property p_blink_count_bound;
    @(posedge sys_clk) disable iff (reset)
      blink_cnt_r <= lad_pkg::BLINK_CNT_W'(lad_pkg::BLINK_HALF_CYCLES - 1);
  endproperty
  a_blink_count_bound: assert property (p_blink_count_bound) else $error("blink count past half period"); // [R9]

  property p_blink_toggle_point;
    @(posedge sys_clk) disable iff (reset)
      $changed(blink_r) |-> $past(blink_cnt_r) == lad_pkg::BLINK_CNT_W'(lad_pkg::BLINK_HALF_CYCLES - 1);
  endproperty
  a_blink_toggle_point: assert property (p_blink_toggle_point) else $error("blink flip off terminal count"); // [R9]

  // four-output layout: a lit link lamp follows the blink phase while traffic flows
  property p_four_link_blink;
    @(posedge sys_clk) disable iff (reset)
      $past(is_four && link100 && any_act) |-> lamp_out.fast_link_indicator == $past(blink_r);
  endproperty
  a_four_link_blink: assert property (p_four_link_blink) else $error("four layout link lamp not blinking"); // [R3]

  property p_six_rx_active;
    @(posedge sys_clk) disable iff (reset)
      $past(layout_r == lad_pkg::LAYOUT_SIX && st.rx_active) |-> lamp_out.receive_activity_indicator == $past(blink_r);
  endproperty
  a_six_rx_active: assert property (p_six_rx_active) else $error("rx lamp not showing receive"); // [R7]

  property p_six_rx_idle;
    @(posedge sys_clk) disable iff (reset)
      $past(layout_r == lad_pkg::LAYOUT_SIX && !st.rx_active) |-> lamp_out.receive_activity_indicator;
  endproperty
  a_six_rx_idle: assert property (p_six_rx_idle) else $error("rx lamp on without receive"); // [R7]

  // write taken at one edge, select at the next, pin enables one edge after that
  sequence s_four_taken;
    layout_wr && layout_wdata[lad_pkg::LAYOUT_MSB:lad_pkg::LAYOUT_LSB] == lad_pkg::LAYOUT_FOUR;
  endsequence

  sequence s_activity_released;
    ##2 (!lamp_oe.transmit_activity_indicator && !lamp_oe.receive_activity_indicator);
  endsequence

  property p_four_write_release;
    @(posedge sys_clk) disable iff (reset)
      s_four_taken |-> s_activity_released;
  endproperty
  a_four_write_release: assert property (p_four_write_release) else $error("four layout write kept pins"); // [R4]
endmodule : lad_driver

// ===== testbench/lad_lamp_model.sv
// Purpose: board lamps with pull-ups on the indicator pins
// Assumes: a pin that is not driven floats up to the pull-up level
// Notes: lamp lit while its pin reads low
`timescale 1ns/1ps
module lad_lamp_model (
  input wire lad_pkg::lad_lamps_t lamp_out,
  input wire lad_pkg::lad_lamps_t lamp_oe,
  output logic [5:0] pin_level
);
  // released pins read high, never the last driven value
  assign pin_level = (lamp_out & lamp_oe) | ~lamp_oe;
endmodule : lad_lamp_model

// ===== testbench/tb.sv
// Purpose: random and corner checks of layout select and lamp pin levels
// Assumes: run ends long before the first 40 ms blink flip
// Notes: blink phase is low throughout, so active lamps read low
`timescale 1ns/1ps
module tb;
  logic sys_clk;
  logic reset;
  logic layout_wr;
  logic [15:0] layout_wdata;
  lad_pkg::lad_status_t status_in;
  logic [1:0] indicator_layout_select;
  lad_pkg::lad_lamps_t lamp_out;
  lad_pkg::lad_lamps_t lamp_oe;
  logic [5:0] pin_level;
  logic [1:0] lay_exp;
  logic [31:0] rng;
  int n_mismatch = 0;
  int compares = 0;
  lad_driver dut_u (.sys_clk(sys_clk), .reset(reset), .layout_wr(layout_wr), .layout_wdata(layout_wdata),
    .status_in(status_in), .indicator_layout_select(indicator_layout_select), .lamp_out(lamp_out),
    .lamp_oe(lamp_oe));
  lad_lamp_model lamp_u (.lamp_out(lamp_out), .lamp_oe(lamp_oe), .pin_level(pin_level));
  // xorshift keeps the random sequence repeatable
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // expected pin levels with the blink phase still low
  function automatic logic [5:0] exp_pins(input logic [1:0] lay, input lad_pkg::lad_status_t s);
    logic [5:0] e;
    e[5] = (lay == lad_pkg::LAYOUT_SIX) ? ~s.tx_active :
           (lay == lad_pkg::LAYOUT_FIVE) ? ~(s.tx_active | s.rx_active) : 1'b1;
    e[4] = (lay == lad_pkg::LAYOUT_SIX) ? ~s.rx_active : 1'b1;
    e[3] = s.collision ? 1'b0 : ~s.full_duplex;
    for (int i = 0; i < 3; i++) begin
      e[i] = ~(s.link_up && (s.speed == 2'(i)));
    end
    return e;
  endfunction : exp_pins
  // expected drive enables; a pulled-up pin reads high either way, so only the enable tells
  function automatic logic [5:0] exp_oe(input logic [1:0] lay);
    return (lay == lad_pkg::LAYOUT_FOUR) ? 6'h0F : (lay == lad_pkg::LAYOUT_FIVE) ? 6'h2F : 6'h3F;
  endfunction : exp_oe
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    compares++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // one write plus status change, then compare once lamps have settled
  task automatic step(input logic [1:0] wsel, input lad_pkg::lad_status_t s);
    @(negedge sys_clk);
    layout_wr = 1'b1;
    layout_wdata = {rng[15:8], wsel, rng[5:0]};
    status_in = s;
    if (wsel != lad_pkg::LAYOUT_RESV) lay_exp = wsel;
    @(negedge sys_clk);
    layout_wr = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({6'h00, indicator_layout_select}, {6'h00, lay_exp});
    check({2'h0, pin_level}, {2'h0, exp_pins(lay_exp, s)});
    check({2'h0, lamp_oe}, {2'h0, exp_oe(lay_exp)});
  endtask : step
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // about 300 cycles are needed; 100 us is ample
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [1:0] corner [4];
    lad_pkg::lad_status_t s;
    corner = '{lad_pkg::LAYOUT_FOUR, lad_pkg::LAYOUT_FIVE, lad_pkg::LAYOUT_RESV, lad_pkg::LAYOUT_SIX};
    rng = 32'h0000_4960;
    reset = 1'b1;
    layout_wr = 1'b0;
    layout_wdata = 16'h0000;
    status_in = '0;
    lay_exp = lad_pkg::LAYOUT_RESET;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    check({6'h00, indicator_layout_select}, {6'h00, lad_pkg::LAYOUT_RESET});
    // corners first: each layout, and a reserved write in between
    for (int i = 0; i < 44; i++) begin
      rng = xs(rng);
      s = rng[30:24];
      if (s.speed == 2'h3) s.speed = lad_pkg::LAD_SPD_1000;
      step((i < 4) ? corner[i] : rng[23:22], s);
    end
    // second reset mid-run: layout falls back to six, a reserved write then leaves it there
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    lay_exp = lad_pkg::LAYOUT_RESET;
    check({6'h00, indicator_layout_select}, {6'h00, lad_pkg::LAYOUT_RESET});
    rng = xs(rng);
    s = rng[30:24];
    if (s.speed == 2'h3) s.speed = lad_pkg::LAD_SPD_1000;
    step(lad_pkg::LAYOUT_RESV, s);
    stop_test();
  end
endmodule : tb
